// File: src/tpr_pkg.sv
// constants and carrier types for the touch panel position readout
package tpr_pkg;

  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_CTRL = 8'h20;
  localparam logic [7:0] IDX_STATUS = 8'h21;
  localparam logic [7:0] IDX_INTERVAL = 8'h22;
  localparam logic [7:0] IDX_X_ADC = 8'h24;
  localparam logic [7:0] IDX_Y_ADC = 8'h26;
  localparam logic [7:0] IDX_X_DOT = 8'h28;
  localparam logic [7:0] IDX_Y_DOT = 8'h2a;
  localparam logic [7:0] IDX_CAL_A_X_DOT = 8'h2c;
  localparam logic [7:0] IDX_CAL_A_Y_DOT = 8'h2e;
  localparam logic [7:0] IDX_CAL_B_X_DOT = 8'h30;
  localparam logic [7:0] IDX_CAL_A_X_ADC = 8'h38;
  localparam logic [7:0] IDX_CAL_A_Y_ADC = 8'h3a;
  localparam logic [7:0] IDX_X_SCALE = 8'h44;
  localparam logic [7:0] IDX_Y_SCALE = 8'h46;
  localparam logic [7:0] IDX_UNMAPPED = 8'hff;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CTRL_PANEL_ENABLE_BIT = 0;
  localparam int CTRL_DOWN_IE_BIT = 1;
  localparam int CTRL_LIFT_IE_BIT = 2;
  localparam int STAT_DOWN_FLAG_BIT = 1;
  localparam int STAT_LIFT_FLAG_BIT = 2;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] INTERVAL_RESET = 8'h01;
  localparam logic [15:0] REG16_RESET = 16'h0000;
  localparam logic [11:0] ADC12_RESET = 12'h000;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  // ---------------------------------------------------------------
  // timing and arithmetic
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int SAMPLE_STEP_MS = 20;
  localparam int SAMPLE_STEP_CYCLES = SAMPLE_STEP_MS * (CLK_HZ / 1000);
  localparam int SCALE_DIVISOR = 1000;
  localparam int STABLE_SAMPLES = 3;
  localparam int APPROX_TOL_DEFAULT = 8;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic contact;
    logic [11:0] x;
    logic [11:0] y;
  } tpr_adc_sample_t;

  typedef enum logic [0:0] {
    TPR_PEN_LIFTED = 1'b0,
    TPR_PEN_TOUCHED = 1'b1
  } tpr_pen_state_t;

endpackage : tpr_pkg

// File: src/tpr_touch_panel_readout.sv
// touch panel sampling, pen event detection and register file on ahb-lite
//
// Operation
// (RULE1) lift to touch sets flag, latches positions
// (RULE2) pen-down request when flag set and enabled
// (RULE3) pen-down flag clears on written zero
// (RULE4) touch to lift sets flag, request if enabled
// (RULE5) pen-lift flag clears on zero, one ignored
// (RULE6) both flags read zero after reset
// (RULE7) one-hot field picks 20 to 160 ms
// (RULE8) host writes only single-bit interval values
// (RULE9) interval field resets to 20 ms
// (RULE10) x adc result twelve bits, read-only
// (RULE11) y adc result twelve bits, read-only
// (RULE12) x dot position read-only, valid after calibration
// (RULE13) y dot position read-only, valid after calibration
// (RULE14) point a x dot read-write, resets zero
// (RULE15) point a y dot read-write, resets zero
// (RULE16) point b x dot read-write, resets zero
// (RULE17) pen-down needs three near-equal samples; code accepts three samples near-equal in x alone or in y alone
// (RULE18) dot from scale, point a; skip zero
// (RULE19) sample only while panel enabled; reset off
// (RULE20) results held until next pen-down event
//
// Our own choice: register access over AHB-Lite.
module tpr_touch_panel_readout #(
  parameter int SAMPLE_UNIT_CYCLES = tpr_pkg::SAMPLE_STEP_CYCLES,
  parameter int APPROX_TOL = tpr_pkg::APPROX_TOL_DEFAULT
) (
  input logic hclk,
  input logic hresetn,
  input logic clk_en,
  input logic hsel,
  input logic [31:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [2:0] hsize,
  input logic [31:0] hwdata,
  input logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic adc_start,
  input logic adc_done,
  input tpr_pkg::tpr_adc_sample_t adc_result,
  output logic pen_down_irq,
  output logic pen_lift_irq
);

  // ---------------------------------------------------------------
  // parameter checks
  // ---------------------------------------------------------------
  localparam int UW = (SAMPLE_UNIT_CYCLES > 2) ? $clog2(SAMPLE_UNIT_CYCLES) : 1;
  localparam logic [UW-1:0] UNIT_LAST = UW'(SAMPLE_UNIT_CYCLES - 1);
  localparam logic [11:0] TOL12 = 12'(APPROX_TOL);

  if (SAMPLE_UNIT_CYCLES < 2 || APPROX_TOL < 0 || APPROX_TOL > 4095) begin : g_bad_param
    $error("tpr_touch_panel_readout: unsupported parameter value");
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic pend;
    logic wr;
    logic [7:0] idx;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic panel_enable;
    logic down_ie;
    logic lift_ie;
    logic down_flag;
    logic lift_flag;
    logic down_irq;
    logic lift_irq;
    logic [7:0] interval;
    logic [11:0] x_adc;
    logic [11:0] y_adc;
    logic [15:0] x_dot;
    logic [15:0] y_dot;
    logic [15:0] cal_a_x_dot;
    logic [15:0] cal_a_y_dot;
    logic [15:0] cal_b_x_dot;
    logic [11:0] cal_a_x_adc;
    logic [11:0] cal_a_y_adc;
    logic [15:0] x_scale;
    logic [15:0] y_scale;
    logic [UW-1:0] unit_cnt;
    logic [2:0] step_cnt;
    logic busy;
    logic adc_start;
    tpr_pkg::tpr_pen_state_t pen;
    logic [1:0] hist;
    logic [11:0] px1;
    logic [11:0] py1;
    logic [11:0] px2;
    logic [11:0] py2;
  } tpr_state_t;

  tpr_state_t r;
  tpr_state_t next_r;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic tpr_close(input logic [11:0] a, input logic [11:0] b);
    logic [11:0] d;
    d = (a > b) ? (a - b) : (b - a);
    return d <= TOL12;
  endfunction : tpr_close

  function automatic logic [15:0] tpr_dot(
    input logic [11:0] adc,
    input logic [11:0] a_adc,
    input logic [15:0] a_dot,
    input logic [15:0] scale
  );
    logic signed [16:0] diff;
    logic signed [33:0] prod;
    logic signed [33:0] quo;
    diff = $signed({5'b0_0000, adc}) - $signed({5'b0_0000, a_adc});
    prod = diff * $signed({1'b0, scale});
    quo = prod / $signed(34'(tpr_pkg::SCALE_DIVISOR));
    return a_dot + quo[15:0];
  endfunction : tpr_dot

  function automatic logic [2:0] tpr_step_index(input logic [7:0] sel);
    logic [2:0] idx;
    idx = 3'd0;
    for (int i = 7; i >= 0; i--) begin
      if (sel[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction : tpr_step_index

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  logic accept;
  logic do_write;
  logic status_wr;
  logic down_set;
  logic lift_set;
  logic stable;
  logic [31:0] rd;

  always_comb begin
    next_r = r;
    next_r.adc_start = 1'b0;
    down_set = 1'b0;
    lift_set = 1'b0;
    stable = 1'b0;
    rd = 32'h0000_0000;
    accept = hsel & htrans[1] & hready;
    do_write = r.pend & r.wr;
    status_wr = do_write && (r.idx == tpr_pkg::IDX_STATUS);

    // read mux, reserved bits zero
    case (r.idx)
      tpr_pkg::IDX_CTRL: begin
        rd[tpr_pkg::CTRL_PANEL_ENABLE_BIT] = r.panel_enable;
        rd[tpr_pkg::CTRL_DOWN_IE_BIT] = r.down_ie;
        rd[tpr_pkg::CTRL_LIFT_IE_BIT] = r.lift_ie;
      end
      tpr_pkg::IDX_STATUS: begin
        rd[tpr_pkg::STAT_DOWN_FLAG_BIT] = r.down_flag;
        rd[tpr_pkg::STAT_LIFT_FLAG_BIT] = r.lift_flag;
      end
      tpr_pkg::IDX_INTERVAL: rd[7:0] = r.interval;
      tpr_pkg::IDX_X_ADC: rd[11:0] = r.x_adc; // [RULE10]
      tpr_pkg::IDX_Y_ADC: rd[11:0] = r.y_adc; // [RULE11]
      tpr_pkg::IDX_X_DOT: rd[15:0] = r.x_dot; // [RULE12]
      tpr_pkg::IDX_Y_DOT: rd[15:0] = r.y_dot; // [RULE13]
      tpr_pkg::IDX_CAL_A_X_DOT: rd[15:0] = r.cal_a_x_dot;
      tpr_pkg::IDX_CAL_A_Y_DOT: rd[15:0] = r.cal_a_y_dot;
      tpr_pkg::IDX_CAL_B_X_DOT: rd[15:0] = r.cal_b_x_dot;
      tpr_pkg::IDX_CAL_A_X_ADC: rd[11:0] = r.cal_a_x_adc;
      tpr_pkg::IDX_CAL_A_Y_ADC: rd[11:0] = r.cal_a_y_adc;
      tpr_pkg::IDX_X_SCALE: rd[15:0] = r.x_scale;
      tpr_pkg::IDX_Y_SCALE: rd[15:0] = r.y_scale;
      default: rd = 32'h0000_0000;
    endcase

    // -------------------------------------------------------------
    // bus slave: one wait state, then data phase completes
    // -------------------------------------------------------------
    if (r.pend) begin
      next_r.pend = 1'b0;
      next_r.hreadyout = 1'b1;
      if (!r.wr) begin
        next_r.hrdata = rd;
      end
    end
    if (do_write) begin
      case (r.idx)
        tpr_pkg::IDX_CTRL: begin
          next_r.panel_enable = hwdata[tpr_pkg::CTRL_PANEL_ENABLE_BIT];
          next_r.down_ie = hwdata[tpr_pkg::CTRL_DOWN_IE_BIT];
          next_r.lift_ie = hwdata[tpr_pkg::CTRL_LIFT_IE_BIT];
        end
        tpr_pkg::IDX_INTERVAL: next_r.interval = hwdata[7:0]; // [RULE8]
        tpr_pkg::IDX_CAL_A_X_DOT: next_r.cal_a_x_dot = hwdata[15:0]; // [RULE14]
        tpr_pkg::IDX_CAL_A_Y_DOT: next_r.cal_a_y_dot = hwdata[15:0]; // [RULE15]
        tpr_pkg::IDX_CAL_B_X_DOT: next_r.cal_b_x_dot = hwdata[15:0]; // [RULE16]
        tpr_pkg::IDX_CAL_A_X_ADC: next_r.cal_a_x_adc = hwdata[11:0];
        tpr_pkg::IDX_CAL_A_Y_ADC: next_r.cal_a_y_adc = hwdata[11:0];
        tpr_pkg::IDX_X_SCALE: next_r.x_scale = hwdata[15:0];
        tpr_pkg::IDX_Y_SCALE: next_r.y_scale = hwdata[15:0];
        default: next_r.pend = 1'b0;
      endcase
    end
    if (accept) begin
      next_r.pend = 1'b1;
      next_r.hreadyout = 1'b0;
      next_r.wr = hwrite;
      next_r.idx = (haddr[31:10] == 22'd0) ? haddr[9:2] : tpr_pkg::IDX_UNMAPPED;
    end

    // -------------------------------------------------------------
    // sampling timer
    // -------------------------------------------------------------
    if (!r.panel_enable) begin
      next_r.unit_cnt = '0; // [RULE19]
      next_r.step_cnt = 3'd0;
      next_r.busy = 1'b0;
      next_r.hist = 2'd0;
      next_r.pen = tpr_pkg::TPR_PEN_LIFTED;
    end else begin
      if (r.unit_cnt == UNIT_LAST) begin
        next_r.unit_cnt = '0;
        if (r.step_cnt >= tpr_step_index(r.interval)) begin
          next_r.step_cnt = 3'd0; // [RULE7]
          if (!r.busy) begin
            next_r.adc_start = 1'b1;
            next_r.busy = 1'b1;
          end
        end else begin
          next_r.step_cnt = r.step_cnt + 3'd1;
        end
      end else begin
        next_r.unit_cnt = r.unit_cnt + UW'(1);
      end

      // -----------------------------------------------------------
      // pen detection on each conversion
      // -----------------------------------------------------------
      if (r.busy && adc_done) begin
        next_r.busy = 1'b0;
        if (adc_result.contact) begin
          next_r.px1 = adc_result.x;
          next_r.py1 = adc_result.y;
          next_r.px2 = r.px1;
          next_r.py2 = r.py1;
          next_r.hist = (r.hist == 2'd2) ? 2'd2 : r.hist + 2'd1;
          stable = (r.hist == 2'(tpr_pkg::STABLE_SAMPLES - 1)) && // [RULE17]
                   ((tpr_close(adc_result.x, r.px1) && tpr_close(adc_result.x, r.px2) &&
                     tpr_close(r.px1, r.px2)) ||
                    (tpr_close(adc_result.y, r.py1) && tpr_close(adc_result.y, r.py2) &&
                     tpr_close(r.py1, r.py2)));
          if (stable && r.pen == tpr_pkg::TPR_PEN_LIFTED) begin
            next_r.pen = tpr_pkg::TPR_PEN_TOUCHED;
            down_set = 1'b1; // [RULE1]
            next_r.x_adc = adc_result.x; // [RULE20]
            next_r.y_adc = adc_result.y;
            if (r.x_scale != 16'h0000) begin
              next_r.x_dot = tpr_dot(adc_result.x, r.cal_a_x_adc, r.cal_a_x_dot,
                                     r.x_scale); // [RULE18]
            end
            if (r.y_scale != 16'h0000) begin
              next_r.y_dot = tpr_dot(adc_result.y, r.cal_a_y_adc, r.cal_a_y_dot,
                                     r.y_scale);
            end
          end
        end else begin
          next_r.hist = 2'd0;
          if (r.pen == tpr_pkg::TPR_PEN_TOUCHED) begin
            next_r.pen = tpr_pkg::TPR_PEN_LIFTED;
            lift_set = 1'b1; // [RULE4]
          end
        end
      end
    end

    // -------------------------------------------------------------
    // flags: set wins over a clearing write
    // -------------------------------------------------------------
    next_r.down_flag = down_set | (r.down_flag &
      ~(status_wr & ~hwdata[tpr_pkg::STAT_DOWN_FLAG_BIT])); // [RULE3]
    next_r.lift_flag = lift_set | (r.lift_flag &
      ~(status_wr & ~hwdata[tpr_pkg::STAT_LIFT_FLAG_BIT])); // [RULE5]
    next_r.down_irq = next_r.down_flag & next_r.down_ie; // [RULE2]
    next_r.lift_irq = next_r.lift_flag & next_r.lift_ie; // [RULE4]
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
      r.hreadyout <= 1'b1;
      r.hrdata <= tpr_pkg::RDATA_RESET;
      r.down_flag <= 1'b0; // [RULE6]
      r.lift_flag <= 1'b0;
      r.interval <= tpr_pkg::INTERVAL_RESET; // [RULE9]
      r.cal_a_x_dot <= tpr_pkg::REG16_RESET;
      r.cal_a_y_dot <= tpr_pkg::REG16_RESET;
      r.cal_b_x_dot <= tpr_pkg::REG16_RESET;
      r.x_adc <= tpr_pkg::ADC12_RESET;
      r.y_adc <= tpr_pkg::ADC12_RESET;
      r.pen <= tpr_pkg::TPR_PEN_LIFTED;
    end else if (clk_en) begin
      r <= next_r;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign hrdata = r.hrdata;
  assign hreadyout = r.hreadyout;
  assign hresp = r.hresp;
  assign adc_start = r.adc_start;
  assign pen_down_irq = r.down_irq;
  assign pen_lift_irq = r.lift_irq;

endmodule : tpr_touch_panel_readout

// File: dv/tpr_asserts.sv
// port checker for the touch panel readout
module tpr_asserts #(
  parameter int SAMPLE_UNIT_CYCLES = 20
) (
  input logic hclk,
  input logic hresetn,
  input logic clk_en,
  input logic hsel,
  input logic [1:0] htrans,
  input logic hready,
  input logic hreadyout,
  input logic hresp,
  input logic adc_start,
  input logic adc_done,
  input logic pen_down_irq,
  input logic pen_lift_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic seen;
  int gap;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // cycles since the last conversion request
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seen <= 1'b0;
      gap <= 0;
    end else if (clk_en && adc_start) begin
      seen <= 1'b1;
      gap <= 1;
    end else if (clk_en && gap < 100000) begin
      gap <= gap + 1;
    end
  end
  property p_down_cause;
    $rose(pen_down_irq) |-> $past(adc_done) || !$past(hreadyout);
  endproperty
  a_down_cause: assert property (p_down_cause) else $error("down request without cause");
  property p_lift_cause;
    $rose(pen_lift_irq) |-> $past(adc_done) || !$past(hreadyout);
  endproperty
  a_lift_cause: assert property (p_lift_cause) else $error("lift request without cause");
  property p_down_clear;
    $fell(pen_down_irq) |-> !$past(hreadyout);
  endproperty
  a_down_clear: assert property (p_down_clear) else $error("down request dropped alone");
  property p_lift_clear;
    $fell(pen_lift_irq) |-> !$past(hreadyout);
  endproperty
  a_lift_clear: assert property (p_lift_clear) else $error("lift request dropped alone");
  property p_start_pulse;
    adc_start && clk_en |=> !adc_start;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start longer than one cycle");
  property p_start_spacing;
    adc_start && seen |-> gap >= SAMPLE_UNIT_CYCLES;
  endproperty
  a_start_spacing: assert property (p_start_spacing) else $error("samples too close");
  property p_wait_state;
    hsel && htrans[1] && hready && clk_en |=> !hreadyout ##1 hreadyout;
  endproperty
  a_wait_state: assert property (p_wait_state) else $error("bus answer not one wait");
  property p_okay;
    hreadyout |-> hresp == 1'b0;
  endproperty
  a_okay: assert property (p_okay) else $error("error response seen");
endmodule : tpr_asserts

bind tpr_touch_panel_readout tpr_asserts #(.SAMPLE_UNIT_CYCLES(SAMPLE_UNIT_CYCLES)) i_tpr_asserts (
  .hclk, .hresetn, .clk_en, .hsel, .htrans, .hready, .hreadyout, .hresp, .adc_start,
  .adc_done, .pen_down_irq, .pen_lift_irq);

// File: dv/tpr_adc_model.sv
// converter and panel model answering each conversion request
module tpr_adc_model (
  input logic hclk,
  input logic hresetn,
  input logic adc_start,
  input logic contact,
  input logic [11:0] pos_x,
  input logic [11:0] pos_y,
  input int lat,
  output logic adc_done,
  output tpr_pkg::tpr_adc_sample_t adc_result
);
  timeunit 1ns;
  timeprecision 1ns;
  logic busy;
  int cnt;
  tpr_pkg::tpr_adc_sample_t last;
  // result is only valid in the done cycle, garbage otherwise
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy <= 1'b0;
      cnt <= 0;
      adc_done <= 1'b0;
      last <= '0;
      adc_result <= '1;
    end else begin
      adc_done <= 1'b0;
      adc_result <= ~last;
      if (adc_start) begin
        busy <= 1'b1;
        cnt <= lat;
      end else if (busy && cnt > 0) begin
        cnt <= cnt - 1;
      end else if (busy) begin
        busy <= 1'b0;
        adc_done <= 1'b1;
        adc_result <= {contact, pos_x, pos_y};
        last <= {contact, pos_x, pos_y};
      end
    end
  end
endmodule : tpr_adc_model

// File: dv/testbench.sv
// self-checking testbench for the touch panel readout
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int UNIT = 20;
  localparam int LIM = 2000;
  logic hclk, hresetn, clk_en, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic adc_start, adc_done, pen_down_irq, pen_lift_irq, contact;
  logic [11:0] pos_x, pos_y;
  int lat, num_errors, n_compared, c;
  tpr_pkg::tpr_adc_sample_t adc_result;
  logic [7:0] tab [10] = '{tpr_pkg::IDX_CTRL, tpr_pkg::IDX_STATUS, tpr_pkg::IDX_INTERVAL,
    tpr_pkg::IDX_X_ADC, tpr_pkg::IDX_Y_ADC, tpr_pkg::IDX_X_DOT, tpr_pkg::IDX_Y_DOT,
    tpr_pkg::IDX_CAL_A_X_DOT, tpr_pkg::IDX_CAL_A_Y_DOT, tpr_pkg::IDX_CAL_B_X_DOT};
  assign hready = hreadyout;
  tpr_touch_panel_readout #(.SAMPLE_UNIT_CYCLES(UNIT)) i_tpr_touch_panel_readout (.hclk,
    .hresetn, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
    .hreadyout, .hresp, .adc_start, .adc_done, .adc_result, .pen_down_irq, .pen_lift_irq);
  tpr_adc_model i_tpr_adc_model (.hclk, .hresetn, .adc_start, .contact, .pos_x, .pos_y,
    .lat, .adc_done, .adc_result);
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task results;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // sel 0 start, 1 done, 2 bus ready
  task wait_on(input int sel, output int n);
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while ((sel == 0 ? adc_start : sel == 1 ? adc_done : hreadyout) !== 1'b1 && n < LIM);
    if (n >= LIM) begin
      num_errors++;
      $display("MISMATCH t=%0t wait ran out got=%h exp=%h", $time, 1'b0, 1'b1);
      results();
    end
  endtask : wait_on
  task xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    int n;
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {22'h0, idx, 2'b00};
    wait_on(2, n);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_on(2, n);
    rd = hrdata;
  endtask : xfer
  task wr(input logic [7:0] idx, input logic [31:0] d);
    xfer(1'b1, idx, d);
  endtask : wr
  task rdc(input logic [7:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 32'h0000_0000);
    chk(rd, exp);
  endtask : rdc
  // count conversion requests over k edges
  task starts(input int k);
    c = 0;
    repeat (k) begin
      @(posedge hclk);
      if (adc_start === 1'b1) c++;
    end
  endtask : starts
  task samples(input int k);
    repeat (k) wait_on(1, c);
    @(posedge hclk);
  endtask : samples
  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    hresetn = 1'b0; clk_en = 1'b1; hsel = 1'b0; haddr = '0; htrans = '0; hwrite = 1'b0;
    hsize = 3'b010; hwdata = '0; contact = 1'b0; pos_x = '0; pos_y = '0; lat = 1;
    num_errors = 0; n_compared = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 10; i++) begin
      rdc(tab[i], i == 2 ? 32'h0000_0001 : 32'h0000_0000);
    end
    for (int i = 3; i < 10; i++) begin
      wr(tab[i], 32'hffff_a5c3);
      rdc(tab[i], i > 6 ? 32'h0000_a5c3 : 32'h0000_0000);
    end
    wr(tpr_pkg::IDX_UNMAPPED, 32'h0000_1234);
    rdc(tpr_pkg::IDX_UNMAPPED, 32'h0000_0000);
    starts(3 * UNIT);
    chk(32'(c), 32'h0000_0000);
    for (int n = 0; n < 8; n++) begin
      wr(tpr_pkg::IDX_CTRL, 32'h0000_0000);
      wr(tpr_pkg::IDX_INTERVAL, 32'h0000_0001 << n);
      rdc(tpr_pkg::IDX_INTERVAL, 32'h0000_0001 << n);
      wr(tpr_pkg::IDX_CTRL, 32'h0000_0001);
      wait_on(0, c);
      wait_on(0, c);
      chk(32'(c), 32'((n + 1) * UNIT));
    end
    wr(tpr_pkg::IDX_CTRL, 32'h0000_0000);
    lat <= 5;
    contact <= 1'b1;
    pos_x <= 12'h180;
    pos_y <= 12'h200;
    wr(tpr_pkg::IDX_INTERVAL, 32'h0000_0001);
    wr(tpr_pkg::IDX_CAL_A_X_DOT, 32'h0000_0010);
    wr(tpr_pkg::IDX_CAL_A_X_ADC, 32'h0000_0100);
    wr(tpr_pkg::IDX_X_SCALE, 32'h0000_07d0);
    wr(tpr_pkg::IDX_CTRL, 32'h0000_0007);
    for (int k = 0; k < 3; k++) begin
      samples(1);
      chk({31'h0, pen_down_irq}, {31'h0, k == 2});
    end
    rdc(tpr_pkg::IDX_STATUS, 32'h0000_0002);
    rdc(tpr_pkg::IDX_X_ADC, 32'h0000_0180);
    rdc(tpr_pkg::IDX_Y_ADC, 32'h0000_0200);
    rdc(tpr_pkg::IDX_X_DOT, 32'h0000_0110);
    rdc(tpr_pkg::IDX_Y_DOT, 32'h0000_0000);
    pos_x <= 12'h300;
    samples(2);
    rdc(tpr_pkg::IDX_X_ADC, 32'h0000_0180);
    wr(tpr_pkg::IDX_STATUS, 32'h0000_0006);
    rdc(tpr_pkg::IDX_STATUS, 32'h0000_0002);
    wr(tpr_pkg::IDX_STATUS, 32'h0000_0000);
    rdc(tpr_pkg::IDX_STATUS, 32'h0000_0000);
    chk({31'h0, pen_down_irq}, 32'h0000_0000);
    contact <= 1'b0;
    samples(2);
    chk({31'h0, pen_lift_irq}, 32'h0000_0001);
    wr(tpr_pkg::IDX_STATUS, 32'h0000_0006);
    rdc(tpr_pkg::IDX_STATUS, 32'h0000_0004);
    wr(tpr_pkg::IDX_CTRL, 32'h0000_0003);
    chk({31'h0, pen_lift_irq}, 32'h0000_0000);
    wr(tpr_pkg::IDX_STATUS, 32'h0000_0000);
    rdc(tpr_pkg::IDX_STATUS, 32'h0000_0000);
    wr(tpr_pkg::IDX_CTRL, 32'h0000_0001);
    contact <= 1'b1;
    samples(4);
    chk({31'h0, pen_down_irq}, 32'h0000_0000);
    rdc(tpr_pkg::IDX_STATUS, 32'h0000_0002);
    wait_on(1, c);
    clk_en <= 1'b0;
    starts(3 * UNIT);
    chk(32'(c), 32'h0000_0000);
    clk_en <= 1'b1;
    wr(tpr_pkg::IDX_INTERVAL, 32'h0000_0040);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(tpr_pkg::IDX_STATUS, 32'h0000_0000);
    rdc(tpr_pkg::IDX_INTERVAL, 32'h0000_0001);
    rdc(tpr_pkg::IDX_CTRL, 32'h0000_0000);
    results();
  end
endmodule : testbench
